// [inc/cfg_hdr_pkg.sv]
// Constants and carriers for the configuration header front block.
// Assumes configuration cycles are already decoded to one request per dword.
package cfg_hdr_pkg;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] OFS_CMD   = 8'h04;
  localparam logic [7:0] OFS_STS   = 8'h06;
  localparam logic [7:0] OFS_REV   = 8'h08;
  localparam logic [7:0] OFS_CLASS = 8'h09;
  localparam logic [7:0] OFS_CLS   = 8'h0C;

  // ==========================================================================
  // Command field layout and reset value
  localparam int unsigned CMD_IO     = 0;
  localparam int unsigned CMD_MEM    = 1;
  localparam int unsigned CMD_MASTER = 2;
  localparam int unsigned CMD_MWI    = 4;
  localparam int unsigned CMD_PERR   = 6;
  localparam int unsigned CMD_STEP   = 7;
  localparam int unsigned CMD_SERR   = 8;
  localparam logic [15:0] CMD_WMASK  = 16'h01D7;
  localparam logic [15:0] CMD_RESET  = 16'h0000;

  // ==========================================================================
  // Status field layout
  localparam int unsigned NFLAG = 6;
  localparam int unsigned FLAG_POS [NFLAG] = '{8, 11, 12, 13, 14, 15};
  localparam int unsigned FL_MPERR  = 0;
  localparam int unsigned FL_TABS   = 1;
  localparam int unsigned FL_TABR   = 2;
  localparam int unsigned FL_MABR   = 3;
  localparam int unsigned FL_SERR   = 4;
  localparam int unsigned FL_PERR   = 5;
  localparam logic [15:0] STS_FIXED = 16'h0410;
  localparam logic [15:0] STS_FLAGS = 16'hF900;
  localparam logic [7:0]  CLS_RESET = 8'h00;

  // ==========================================================================
  // Fixed identification and bus commands
  localparam logic [23:0] CLASS_CODE = 24'h06_0700;
  localparam logic [3:0]  BUS_MEM_WR = 4'h7;
  localparam logic [3:0]  BUS_MWI    = 4'hF;

  typedef struct packed {
    logic        sel;
    logic        wr;
    logic [7:0]  addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } cfg_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
  } cfg_rsp_t;

  typedef struct packed {
    logic addr_perr;
    logic data_perr;
    logic perr_seen;
    logic was_master;
    logic mabort_rcvd;
    logic tabort_rcvd;
    logic tabort_sent;
  } err_evt_t;

  typedef struct packed {
    logic io_en;
    logic mem_en;
    logic master_en;
    logic mwi_en;
    logic step_en;
    logic perr_en;
    logic serr_en;
  } cmd_ctl_t;

endpackage

// [src/cfg_front.sv]
// Front of the configuration header: command, status, revision, class,
// cache line size. Assumes the bus interface hands over one dword request
// per configuration cycle and reports error events as one-cycle pulses.
module cfg_front #(
  parameter logic [7:0] REVISION_CODE = 8'h3C  // Arbitrary value
) (
  input  wire logic                  mclk,        // Clock, 100 MHz
  input  wire logic                  reset,       // Synchronous reset
  input  wire logic                  ce,          // Clock enable
  input  wire cfg_hdr_pkg::cfg_req_t cfg_req,     // Configuration request
  output cfg_hdr_pkg::cfg_rsp_t      cfg_rsp,     // Configuration answer
  input  wire cfg_hdr_pkg::err_evt_t err_evt,     // Error event pulses
  input  wire logic                  mst_req,     // Master wants the bus
  input  wire logic                  mst_wr,      // Master cycle is a write
  input  wire logic                  io_hit,      // I/O address decode hit
  input  wire logic                  mem_hit,     // Memory address decode hit
  output cfg_hdr_pkg::cmd_ctl_t      cmd_ctl,     // Command enables
  output logic                       mst_req_q,   // Gated bus request
  output logic [3:0]                 mst_cmd_q,   // Bus command for master write cycle
  output logic                       io_claim_q,  // Claim I/O cycle
  output logic                       mem_claim_q, // Claim memory cycle
  output logic                       serr_q,      // System error pulse
  output logic                       perr_q       // Parity error pulse
);

  // ==========================================================================
  // Decode
  logic        hit_cmd;
  logic        hit_rev;
  logic        hit_cls;
  logic        wr_cmd;
  logic        wr_cls;
  logic [15:0] cmd_r;
  logic [15:0] cmd_nxt;
  logic [7:0]  cls_r;
  logic [15:0] sts_w1c;
  logic [15:0] sts_val;
  logic [cfg_hdr_pkg::NFLAG-1:0] flag_set;
  logic [cfg_hdr_pkg::NFLAG-1:0] flag_q;
  logic        addr_rep;
  logic [31:0] rdata_nxt;

  assign hit_cmd = cfg_req.sel && (cfg_req.addr[7:2] == cfg_hdr_pkg::OFS_CMD[7:2]);
  assign hit_rev = cfg_req.sel && (cfg_req.addr[7:2] == cfg_hdr_pkg::OFS_REV[7:2]);
  assign hit_cls = cfg_req.sel && (cfg_req.addr[7:2] == cfg_hdr_pkg::OFS_CLS[7:2]);
  assign wr_cmd  = hit_cmd && cfg_req.wr;
  assign wr_cls  = hit_cls && cfg_req.wr && cfg_req.be[cfg_hdr_pkg::OFS_CLS[1:0]];

  // ==========================================================================
  // Command register
  // Only the writable mask reaches the flops; hardwired bits stay zero.
  always_comb begin
    cmd_nxt = cmd_r;
    if (wr_cmd && cfg_req.be[0]) begin
      cmd_nxt[7:0] = cfg_req.wdata[7:0] & cfg_hdr_pkg::CMD_WMASK[7:0];
    end
    if (wr_cmd && cfg_req.be[1]) begin
      cmd_nxt[15:8] = cfg_req.wdata[15:8] & cfg_hdr_pkg::CMD_WMASK[15:8];
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      cmd_r <= cfg_hdr_pkg::CMD_RESET;
    end else if (ce) begin
      cmd_r <= cmd_nxt;
    end
  end

  assign cmd_ctl.io_en     = cmd_r[cfg_hdr_pkg::CMD_IO];
  assign cmd_ctl.mem_en    = cmd_r[cfg_hdr_pkg::CMD_MEM];
  assign cmd_ctl.master_en = cmd_r[cfg_hdr_pkg::CMD_MASTER];
  assign cmd_ctl.mwi_en    = cmd_r[cfg_hdr_pkg::CMD_MWI];
  assign cmd_ctl.step_en   = cmd_r[cfg_hdr_pkg::CMD_STEP];
  assign cmd_ctl.perr_en   = cmd_r[cfg_hdr_pkg::CMD_PERR];
  assign cmd_ctl.serr_en   = cmd_r[cfg_hdr_pkg::CMD_SERR];

  // ==========================================================================
  // Cache line size
  always_ff @(posedge mclk) begin
    if (reset) begin
      cls_r <= cfg_hdr_pkg::CLS_RESET;
    end else if (ce && wr_cls) begin
      cls_r <= cfg_req.wdata[7:0];
    end
  end

  // ==========================================================================
  // Master and target gating
  always_ff @(posedge mclk) begin
    if (reset) begin
      mst_req_q <= 1'b0;
      mst_cmd_q <= cfg_hdr_pkg::BUS_MEM_WR;
    end else if (ce) begin
      mst_req_q <= mst_req && cmd_r[cfg_hdr_pkg::CMD_MASTER];
      if (mst_req && mst_wr) begin
        mst_cmd_q <= cmd_r[cfg_hdr_pkg::CMD_MWI] ? cfg_hdr_pkg::BUS_MWI
                                                  : cfg_hdr_pkg::BUS_MEM_WR;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      io_claim_q  <= 1'b0;
      mem_claim_q <= 1'b0;
    end else if (ce) begin
      io_claim_q  <= io_hit && cmd_r[cfg_hdr_pkg::CMD_IO];
      mem_claim_q <= mem_hit && cmd_r[cfg_hdr_pkg::CMD_MEM];
    end
  end

  // ==========================================================================
  // Error signalling
  // Address parity raises a system error only when both SERR and parity enables are set.
  assign addr_rep = err_evt.addr_perr && cmd_r[cfg_hdr_pkg::CMD_SERR]
                    && cmd_r[cfg_hdr_pkg::CMD_PERR];

  always_ff @(posedge mclk) begin
    if (reset) begin
      serr_q <= 1'b0;
      perr_q <= 1'b0;
    end else if (ce) begin
      serr_q <= addr_rep;
      perr_q <= err_evt.addr_perr && cmd_r[cfg_hdr_pkg::CMD_PERR];
    end
  end

  // ==========================================================================
  // Status flags
  assign flag_set[cfg_hdr_pkg::FL_PERR]  = err_evt.addr_perr || err_evt.data_perr;
  assign flag_set[cfg_hdr_pkg::FL_SERR]  = addr_rep;
  assign flag_set[cfg_hdr_pkg::FL_MABR]  = err_evt.mabort_rcvd;
  assign flag_set[cfg_hdr_pkg::FL_TABR]  = err_evt.tabort_rcvd;
  assign flag_set[cfg_hdr_pkg::FL_TABS]  = err_evt.tabort_sent;
  assign flag_set[cfg_hdr_pkg::FL_MPERR] = err_evt.perr_seen && err_evt.was_master
                                           && cmd_r[cfg_hdr_pkg::CMD_PERR];

  // Status sits in the upper half of the command dword
  assign sts_w1c[15:8] = (wr_cmd && cfg_req.be[3]) ? cfg_req.wdata[31:24] : 8'h00;
  assign sts_w1c[7:0]  = (wr_cmd && cfg_req.be[2]) ? cfg_req.wdata[23:16] : 8'h00;

  for (genvar i = 0; i < cfg_hdr_pkg::NFLAG; i++) begin : g_flag
    sticky_flag u_flag (
      .mclk    (mclk),
      .reset   (reset),
      .ce      (ce),
      .set_evt (flag_set[i]),
      .clr_req (sts_w1c[cfg_hdr_pkg::FLAG_POS[i]]),
      .flag_q  (flag_q[i])
    );
  end

  always_comb begin
    sts_val = cfg_hdr_pkg::STS_FIXED;
    for (int k = 0; k < cfg_hdr_pkg::NFLAG; k++) begin
      sts_val[cfg_hdr_pkg::FLAG_POS[k]] = flag_q[k];
    end
  end

  // ==========================================================================
  // Read path, answered one enabled cycle after the request
  // Unmapped dwords read zero so software sees an empty slot.
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (hit_cmd) begin
      rdata_nxt = {sts_val, cmd_r};
    end else if (hit_rev) begin
      rdata_nxt = {cfg_hdr_pkg::CLASS_CODE, REVISION_CODE};
    end else if (hit_cls) begin
      rdata_nxt = {24'h00_0000, cls_r};
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      cfg_rsp <= '0;
    end else if (ce) begin
      cfg_rsp.ack   <= cfg_req.sel;
      cfg_rsp.rdata <= (cfg_req.sel && !cfg_req.wr) ? rdata_nxt : 32'h0000_0000;
    end
  end

  // ==========================================================================
  // Assertions
  logic        rd_cmd_q;
  logic        rd_rev_q;
  always_ff @(posedge mclk) begin
    if (reset) begin
      rd_cmd_q <= 1'b0;
      rd_rev_q <= 1'b0;
    end else if (ce) begin
      rd_cmd_q <= hit_cmd && !cfg_req.wr;
      rd_rev_q <= hit_rev && !cfg_req.wr;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  property p_cmd_hi_zero;
    rd_cmd_q |-> cfg_rsp.rdata[15:10] == 6'b00_0000;
  endproperty
  a_cmd_hi_zero: assert property (p_cmd_hi_zero)
    else $error("command upper bits not zero");

  property p_cmd_hardwired;
    rd_cmd_q |-> {cfg_rsp.rdata[9], cfg_rsp.rdata[5], cfg_rsp.rdata[3]} == 3'b000;
  endproperty
  a_cmd_hardwired: assert property (p_cmd_hardwired)
    else $error("hardwired command bit set");

  property p_serr_cause;
    serr_q && $past(ce) |-> $past(err_evt.addr_perr) && $past(cmd_r[8]) && $past(cmd_r[6]);
  endproperty
  a_serr_cause: assert property (p_serr_cause)
    else $error("system error without enabled cause");

  property p_perr_gate;
    ce && err_evt.addr_perr && cmd_r[6] |=> perr_q;
  endproperty
  a_perr_gate: assert property (p_perr_gate)
    else $error("parity error not signalled");

  property p_mwi_sel;
    ce && mst_req && mst_wr |=> mst_cmd_q == ($past(cmd_r[4]) ? 4'hF : 4'h7);
  endproperty
  a_mwi_sel: assert property (p_mwi_sel)
    else $error("wrong master write command");

  property p_master_gate;
    mst_req_q && $past(ce) |-> $past(cmd_r[2]) && $past(mst_req);
  endproperty
  a_master_gate: assert property (p_master_gate)
    else $error("bus request while mastering disabled");

  property p_claim_gate;
    (mem_claim_q && $past(ce) |-> $past(cmd_r[1]))
      and (io_claim_q && $past(ce) |-> $past(cmd_r[0]));
  endproperty
  a_claim_gate: assert property (p_claim_gate)
    else $error("cycle claimed while space disabled");

  property p_perr_flag;
    ce && (err_evt.addr_perr || err_evt.data_perr) |=> flag_q[5] ##1 flag_q[5] || $past(ce);
  endproperty
  a_perr_flag: assert property (p_perr_flag)
    else $error("parity flag not set");

  property p_mabort_flag;
    ce && err_evt.mabort_rcvd |=> flag_q[3];
  endproperty
  a_mabort_flag: assert property (p_mabort_flag)
    else $error("master abort flag not set");

  property p_sts_fixed;
    rd_cmd_q |-> cfg_rsp.rdata[26:25] == 2'b10 && cfg_rsp.rdata[20] == 1'b1
                 && cfg_rsp.rdata[23:21] == 3'b000 && cfg_rsp.rdata[19:16] == 4'h0;
  endproperty
  a_sts_fixed: assert property (p_sts_fixed)
    else $error("status fixed bits wrong");

  property p_class_read;
    rd_rev_q |-> cfg_rsp.rdata[31:8] == 24'h06_0700 && cfg_rsp.ack;
  endproperty
  a_class_read: assert property (p_class_read)
    else $error("class code wrong");

  property p_mperr_flag;
    ce && err_evt.perr_seen && err_evt.was_master && cmd_r[6] |=> flag_q[0];
  endproperty
  a_mperr_flag: assert property (p_mperr_flag)
    else $error("master parity flag not set");

  property p_serr_flag;
    ce && err_evt.addr_perr && cmd_r[8] && cmd_r[6] |=> flag_q[4];
  endproperty
  a_serr_flag: assert property (p_serr_flag)
    else $error("system error flag not set");

  property p_tabr_flag;
    ce && err_evt.tabort_rcvd |=> flag_q[2];
  endproperty
  a_tabr_flag: assert property (p_tabr_flag)
    else $error("received target abort flag not set");

  property p_tabs_flag;
    ce && err_evt.tabort_sent |=> flag_q[1];
  endproperty
  a_tabs_flag: assert property (p_tabs_flag)
    else $error("signalled target abort flag not set");

  property p_rev_read;
    rd_rev_q |-> cfg_rsp.rdata[7:0] == REVISION_CODE;
  endproperty
  a_rev_read: assert property (p_rev_read)
    else $error("revision code wrong");

  property p_cls_store;
    ce && wr_cls |=> cls_r == $past(cfg_req.wdata[7:0]);
  endproperty
  a_cls_store: assert property (p_cls_store)
    else $error("cache line size not stored");

  property p_flag_clear;
    ce && sts_w1c[13] && !err_evt.mabort_rcvd |=> !flag_q[3];
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("flag not cleared by write of one");

  property p_perr_quiet;
    ce && !cmd_r[6] |=> !perr_q;
  endproperty
  a_perr_quiet: assert property (p_perr_quiet)
    else $error("parity error signalled while disabled");

  c_serr:   cover property (serr_q);
  c_w1c:    cover property (flag_q[3] ##1 !flag_q[3]);
  c_race:   cover property (ce && err_evt.mabort_rcvd && sts_w1c[13]);
  c_master: cover property (mst_req_q && mst_cmd_q == 4'hF);

endmodule // cfg_front

// [src/sticky_flag.sv]
// One status flag: hardware sets it, software clears it by writing one.
// Assumes set and clear arrive synchronous to mclk.
module sticky_flag (
  input  wire logic mclk,     // Clock
  input  wire logic reset,    // Synchronous reset, active high
  input  wire logic ce,       // Clock enable
  input  wire logic set_evt,  // Hardware event
  input  wire logic clr_req,  // Software write of one
  output logic      flag_q    // Flag state
);

  // ==========================================================================
  // Set beats clear so an event in the clearing cycle is kept
  always_ff @(posedge mclk) begin
    if (reset) begin
      flag_q <= 1'b0;
    end else if (ce) begin
      if (set_evt) begin
        flag_q <= 1'b1;
      end else if (clr_req) begin
        flag_q <= 1'b0;
      end
    end
  end

endmodule // sticky_flag

// [test/host_cfg_model.sv]
// Host-side model that issues configuration reads and writes to the front block.
// Assumes one request per call, driven after a rising edge and answered one edge later.
module host_cfg_model (
  input  wire logic                  mclk,    // Clock
  output cfg_hdr_pkg::cfg_req_t      cfg_req, // Request to the block
  input  wire cfg_hdr_pkg::cfg_rsp_t cfg_rsp  // Answer from the block
);
  timeunit 1ns;
  timeprecision 1ps;

  initial cfg_req = '0;

  // ==========================================================================
  // One transfer; gap idle cycles first, so requests can start promptly or late
  task automatic xfer(input logic wr, input logic [7:0] addr, input logic [3:0] be,
                      input logic [31:0] wd, input int gap, output logic [31:0] rd);
    repeat (gap) @(posedge mclk);
    @(posedge mclk);
    cfg_req <= '{sel: 1'b1, wr: wr, addr: addr, be: be, wdata: wd};
    @(posedge mclk);
    // Released lines carry the inverse so stale data cannot pass for a match
    cfg_req <= '{sel: 1'b0, wr: ~wr, addr: ~addr, be: ~be, wdata: ~wd};
    #1;
    rd = (cfg_rsp.ack === 1'b1) ? cfg_rsp.rdata : 32'hxxxx_xxxx;
  endtask
endmodule // host_cfg_model

// [test/test_cfg_front.sv]
// Self-checking bench for the configuration header front block.
// Assumes the host model drives requests; events and decode hits come from here.
module test_cfg_front;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [7:0] REV = 8'h5A; // Arbitrary value

  logic                  mclk = 1'b0;
  logic                  reset = 1'b1;
  logic                  ce = 1'b1;
  cfg_hdr_pkg::cfg_req_t cfg_req;
  cfg_hdr_pkg::cfg_rsp_t cfg_rsp;
  cfg_hdr_pkg::err_evt_t err_evt = '0;
  logic                  mst_req = 1'b0;
  logic                  mst_wr = 1'b0;
  logic                  io_hit = 1'b0;
  logic                  mem_hit = 1'b0;
  cfg_hdr_pkg::cmd_ctl_t cmd_ctl;
  logic                  mst_req_q;
  logic [3:0]            mst_cmd_q;
  logic                  io_claim_q;
  logic                  mem_claim_q;
  logic                  serr_q;
  logic                  perr_q;
  int                    errors = 0;
  int                    n_tests = 0;
  int                    cycles = 0;
  logic [31:0]           d;
  logic                  s;
  logic                  p;

  always #5 mclk = ~mclk;

  cfg_front #(.REVISION_CODE(REV)) cfg_front_i (
    .mclk(mclk), .reset(reset), .ce(ce), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp),
    .err_evt(err_evt), .mst_req(mst_req), .mst_wr(mst_wr), .io_hit(io_hit),
    .mem_hit(mem_hit), .cmd_ctl(cmd_ctl), .mst_req_q(mst_req_q), .mst_cmd_q(mst_cmd_q),
    .io_claim_q(io_claim_q), .mem_claim_q(mem_claim_q), .serr_q(serr_q), .perr_q(perr_q)
  );

  host_cfg_model host_cfg_model_i (.mclk(mclk), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp));

  // ==========================================================================
  // Shared helpers
  task automatic final_report;
    $display("errors %0d tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      errors++;
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    host_cfg_model_i.xfer(1'b0, a, 4'hF, 32'h0000_0000, 0, v);
  endtask

  // Writes answer with zero data
  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] v);
    logic [31:0] r;
    host_cfg_model_i.xfer(1'b1, a, be, v, 1, r);
    chk(r, 32'h0000_0000);
  endtask

  // One-cycle event pulse, then the registered error outputs one cycle later
  task automatic pulse(input logic [6:0] e);
    @(posedge mclk);
    err_evt <= cfg_hdr_pkg::err_evt_t'(e);
    @(posedge mclk);
    err_evt <= '0;
    #1;
    s = serr_q;
    p = perr_q;
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_reset_values;
    rd(cfg_hdr_pkg::OFS_CMD, d);
    chk(d, 32'h0410_0000);
    rd(cfg_hdr_pkg::OFS_REV, d);
    chk(d, {cfg_hdr_pkg::CLASS_CODE, REV});
    rd(cfg_hdr_pkg::OFS_CLS, d);
    chk(d, 32'h0000_0000);
    rd(8'h10, d);
    chk(d, 32'h0000_0000);
  endtask

  task automatic t_cmd_mask;
    wr(cfg_hdr_pkg::OFS_CMD, 4'hF, 32'hFBFF_FFFF);
    rd(cfg_hdr_pkg::OFS_CMD, d);
    chk(d, 32'h0410_01D7);
    chk({25'h0, cmd_ctl}, 32'h0000_007F);
    wr(cfg_hdr_pkg::OFS_CMD, 4'h3, 32'h0000_0000);
    chk({25'h0, cmd_ctl}, 32'h0000_0000);
    wr(cfg_hdr_pkg::OFS_CLS, 4'h1, 32'h0000_0040);
    rd(cfg_hdr_pkg::OFS_CLS, d);
    chk(d, 32'h0000_0040);
  endtask

  task automatic t_gating;
    for (int en = 1; en >= 0; en--) begin
      wr(cfg_hdr_pkg::OFS_CMD, 4'h3, en ? 32'h0000_0017 : 32'h0000_0000);
      @(posedge mclk);
      {mst_req, mst_wr, io_hit, mem_hit} <= 4'hF;
      @(posedge mclk);
      {mst_req, mst_wr, io_hit, mem_hit} <= 4'h0;
      #1;
      chk({31'h0, mst_req_q}, en);
      chk({28'h0, mst_cmd_q}, en ? 32'h0000_000F : 32'h0000_0007);
      chk({31'h0, io_claim_q}, en);
      chk({31'h0, mem_claim_q}, en);
    end
  endtask

  task automatic t_events;
    wr(cfg_hdr_pkg::OFS_CMD, 4'h3, 32'h0000_0140);
    pulse(7'h40);
    chk({30'h0, s, p}, 32'h0000_0003);
    @(posedge mclk);
    #1;
    chk({30'h0, serr_q, perr_q}, 32'h0000_0000);
    pulse(7'h01);
    pulse(7'h04);
    pulse(7'h02);
    pulse(7'h38);
    rd(cfg_hdr_pkg::OFS_CMD, d);
    chk(d, 32'hFD10_0140);
    wr(cfg_hdr_pkg::OFS_CMD, 4'hC, 32'hF900_0140);
    rd(cfg_hdr_pkg::OFS_CMD, d);
    chk(d, 32'h0410_0140);
    wr(cfg_hdr_pkg::OFS_CMD, 4'h3, 32'h0000_0100);
    pulse(7'h40);
    chk({30'h0, s, p}, 32'h0000_0000);
    pulse(7'h20);
    pulse(7'h18);
    rd(cfg_hdr_pkg::OFS_CMD, d);
    chk(d, 32'h8410_0100);
  endtask

  // Clock enable low must freeze every flop, events and requests included
  task automatic t_freeze;
    wr(cfg_hdr_pkg::OFS_CMD, 4'h3, 32'h0000_0004);
    @(posedge mclk);
    ce      <= 1'b0;
    mst_req <= 1'b1;
    pulse(7'h04);
    chk({31'h0, mst_req_q}, 32'h0000_0000);
    @(posedge mclk);
    ce      <= 1'b1;
    mst_req <= 1'b0;
    rd(cfg_hdr_pkg::OFS_CMD, d);
    chk(d, 32'h8410_0004);
  endtask

  // Event and write-one clear on the same edge: the event is kept
  task automatic t_set_wins;
    fork
      pulse(7'h04);
      host_cfg_model_i.xfer(1'b1, cfg_hdr_pkg::OFS_CMD, 4'h8, 32'h2000_0000, 0, d);
    join
    chk(d, 32'h0000_0000);
    rd(cfg_hdr_pkg::OFS_CMD, d);
    chk(d, 32'hA410_0004);
    wr(cfg_hdr_pkg::OFS_CMD, 4'h8, 32'h2000_0000);
    rd(cfg_hdr_pkg::OFS_CMD, d);
    chk(d, 32'h8410_0004);
  endtask

  // A second reset in mid-run must bring back every reset value
  task automatic t_mid_reset;
    @(posedge mclk);
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    rd(cfg_hdr_pkg::OFS_CMD, d);
    chk(d, 32'h0410_0000);
    rd(cfg_hdr_pkg::OFS_CLS, d);
    chk(d, 32'h0000_0000);
    chk({28'h0, mst_cmd_q}, 32'h0000_0007);
  endtask

  // ==========================================================================
  // Hang guard: the whole run needs under a hundred cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      final_report();
    end
  end

  initial begin
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
    t_reset_values();
    t_cmd_mask();
    t_gating();
    t_events();
    t_freeze();
    t_set_wins();
    t_mid_reset();
    final_report();
  end
endmodule // test_cfg_front
